// [mcc_clock_ctrl.sv]
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module mcc_clock_ctrl
  import mcc_pkg::*;
#(
  parameter int LSE_TMO = mcc_pkg::LSE_TMO_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  input  wire logic [6:0]  i_osc_rdy,
  input  wire logic        i_hse_tick,
  input  wire logic        i_lse_tick,
  input  wire logic        i_msi_tick,
  input  wire logic        i_root_tick,
  input  wire logic        i_stop_mode,
  input  wire logic        i_standby,
  output logic [1:0]       o_root_sel,
  output logic             o_root_gate,
  output logic [3:0]       o_msi_range,
  output logic [7:0]       o_msi_trim,
  output logic [1:0]       o_pll_src,
  output logic [3:0]       o_pll_n,
  output logic [1:0]       o_pll_m,
  output logic [2:0]       o_pll_out_en,
  output logic             o_ahb_tick,
  output logic             o_apb1_tick,
  output logic             o_apb2_tick,
  output logic             o_core_clk_en,
  output logic [1:0]       o_mem_clk_en,
  output logic [15:0]      o_periph_clk_en,
  output logic [1:0]       o_lse_drive,
  output logic             o_lse_bypass,
  output logic [13:0]      o_kernel_sel,
  output logic [1:0]       o_rtc_sel,
  output logic             o_rf_slow_sel,
  output logic [2:0]       o_mco_sel,
  output logic             o_mco_en,
  output logic             o_slow_clock_output_sel,
  output logic             o_slow_clock_output_en,
  output logic             o_css_irq
);
  import mcc_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [31:0] ctrl_r, cfg_r, gate_r, ksel_r;
  logic [2:0]  flag_r;
  logic [7:0]  trim_r;
  mcc_sw_t     st_r, st_nxt;
  logic [1:0]  tgt_r;
  logic        hse_fail, lse_fail;

  wire         wr_ctrl = i_wr && i_addr == OFS_CTRL;
  wire         wr_cfg  = i_wr && i_addr == OFS_CFG;
  wire         wr_gate = i_wr && i_addr == OFS_GATE;
  wire         wr_ksel = i_wr && i_addr == OFS_KSEL;
  wire         wr_clr  = i_wr && i_addr == OFS_CLR;
  wire         css_en  = ctrl_r[5];
  wire         lcss_en = ctrl_r[6];
  wire         auto_tr = ctrl_r[4];
  wire [1:0]   req     = cfg_r[1:0];
  wire         on_hse  = o_root_sel == ROOT_HSE ||
                         (o_root_sel == ROOT_PLL && cfg_r[3:2] == ROOT_PLL);
  wire         css_hit = hse_fail && css_en && on_hse;
  wire         tgt_rdy = i_osc_rdy[tgt_r];

  // ----------------------------------------
  // frequency checks
  // ----------------------------------------
  function automatic logic [19:0] msi_khz(input logic [3:0] r);
    case (r)
      4'h0: msi_khz = 20'd100;
      4'h1: msi_khz = 20'd200;
      4'h2: msi_khz = 20'd400;
      4'h3: msi_khz = 20'd800;
      4'h4: msi_khz = 20'd1000;
      4'h5: msi_khz = 20'd2000;
      4'h6: msi_khz = 20'd4000;
      4'h7: msi_khz = 20'd8000;
      4'h8: msi_khz = 20'd16000;
      4'h9: msi_khz = 20'd24000;
      4'ha: msi_khz = 20'd32000;
      default: msi_khz = 20'd48000;
    endcase
  endfunction

  function automatic logic [19:0] pll_khz(input logic [1:0] s,
      input logic [3:0] n, input logic [1:0] m, input logic [3:0] r);
    logic [19:0] src;
    src = s == 2'h1 ? msi_khz(r) : s == 2'h2 ? HSI_KHZ
        : s == 2'h3 ? HSE_KHZ : 20'd0;
    pll_khz = 20'((24'(src) * 24'(n)) / 24'({1'b0, m} + 3'h1));
  endfunction

  // pll settings that would overrun 64 MHz are refused whole
  wire [19:0] cand_khz = pll_khz(i_wdata[3:2], i_wdata[7:4],
                                 i_wdata[9:8], ctrl_r[3:0]);
  wire        pll_bad  = wr_cfg && cand_khz > FMAX_KHZ;
  // a range that would push an msi-fed pll past the ceiling is kept out
  wire [19:0] rng_pll  = pll_khz(cfg_r[3:2], cfg_r[7:4], cfg_r[9:8],
                                 i_wdata[3:0]);
  wire [3:0]  rng_w    = i_wdata[3:0] < MSI_RANGES && rng_pll <= FMAX_KHZ
                         ? i_wdata[3:0] : ctrl_r[3:0];
  wire [19:0] cur_pll  = pll_khz(cfg_r[3:2], cfg_r[7:4], cfg_r[9:8],
                                 ctrl_r[3:0]);
  wire [19:0] root_khz = o_root_sel == ROOT_MSI ? msi_khz(ctrl_r[3:0])
                       : o_root_sel == ROOT_HSI ? HSI_KHZ
                       : o_root_sel == ROOT_HSE ? HSE_KHZ : cur_pll;
  wire [2:0]  ahb_div_w = cfg_r[15:13];
  wire [19:0] ahb_khz   = root_khz >> ahb_div_w;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= {8'h00, MSI_TRIM_RST, 12'h000, MSI_RANGE_RST};
      cfg_r  <= 32'h0000_0000;
      gate_r <= GATE_RST;
      ksel_r <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)
        ctrl_r <= {8'h00, i_wdata[23:16], 4'h0, i_wdata[11:4], rng_w};
      // a range change keeps the pll limit intact
      if (wr_cfg && !pll_bad)
        cfg_r <= {10'h000, i_wdata[21:0]};
      // the forced fallback becomes the standing request, else the
      // sequencer would move straight back to the dead crystal
      if (css_hit)
        cfg_r[1:0] <= ROOT_HSI;
      if (wr_gate)
        gate_r <= i_wdata;
      if (wr_ksel)
        ksel_r <= {6'h00, i_wdata[25:0]};
    end
  end

  // ----------------------------------------
  // glitch-free root switch
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SW_IDLE: if (css_hit || req != o_root_sel) st_nxt = SW_WAIT;
      SW_WAIT: if (tgt_rdy) st_nxt = SW_OFF;
      SW_OFF:  st_nxt = SW_SWAP;
      SW_SWAP: st_nxt = SW_ON;
      SW_ON:   st_nxt = SW_IDLE;
      default: st_nxt = SW_IDLE;
    endcase
  end

  // old clock gated off before the mux moves, on again after
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r        <= SW_IDLE;
      tgt_r       <= ROOT_MSI;
      o_root_sel  <= ROOT_MSI;
      o_root_gate <= 1'b1;
    end else begin
      st_r <= st_nxt;
      if (css_hit)
        tgt_r <= ROOT_HSI;
      else if (st_r == SW_IDLE)
        tgt_r <= req;
      if (st_r == SW_OFF)
        o_root_gate <= 1'b0;
      if (st_r == SW_SWAP)
        o_root_sel <= tgt_r;
      if (st_r == SW_ON)
        o_root_gate <= 1'b1;
    end
  end

  // ----------------------------------------
  // failure monitors and flags
  // ----------------------------------------
  mcc_fail_mon #(.LIMIT(HSE_TMO_CYC)) u_hse_mon (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_enable  (css_en & i_osc_rdy[2]),
    .i_tick    (i_hse_tick),
    .o_fail    (hse_fail)
  );
  mcc_fail_mon #(.LIMIT(LSE_TMO)) u_lse_mon (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_enable  (lcss_en & i_osc_rdy[4]),
    .i_tick    (i_lse_tick),
    .o_fail    (lse_fail)
  );

  wire [2:0] flag_set = {pll_bad, lse_fail & lcss_en, css_hit};
  wire [2:0] flag_clr = wr_clr ? i_wdata[5:3] : 3'h0;
  wire       irq_nxt  = (flag_r[0] & ctrl_r[10]) | (flag_r[1] & ctrl_r[11]);

  // set wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_r    <= 3'h0;
      o_css_irq <= 1'b0;
    end else begin
      flag_r    <= (flag_r & ~flag_clr) | flag_set;
      o_css_irq <= irq_nxt;
    end
  end

  // ----------------------------------------
  // multispeed rc auto-trim against slow crystal
  // ----------------------------------------
  logic [11:0] mcnt_r;
  wire  [11:0] expect_c = 12'((24'(msi_khz(ctrl_r[3:0])) * 24'd125) >> 12);
  wire  [11:0] band     = (expect_c >> 9) + 12'h001;
  wire         trim_go  = auto_tr && i_osc_rdy[4] && i_lse_tick;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      mcnt_r <= 12'h000;
      trim_r <= MSI_TRIM_RST;
    end else begin
      if (i_lse_tick)
        mcnt_r <= 12'h000;
      else if (i_msi_tick && mcnt_r != 12'hfff)
        mcnt_r <= mcnt_r + 12'h001;
      if (wr_ctrl)
        trim_r <= i_wdata[23:16];
      else if (trim_go && mcnt_r + band < expect_c && trim_r != 8'hff)
        trim_r <= trim_r + 8'h01;
      else if (trim_go && mcnt_r > expect_c + band && trim_r != 8'h00)
        trim_r <= trim_r - 8'h01;
    end
  end

  // ----------------------------------------
  // bus prescalers
  // ----------------------------------------
  logic ahb_t, apb1_t, apb2_t;
  mcc_prescaler #(.W(7)) u_ahb (
    .i_sys_clk  (i_sys_clk),
    .i_reset    (i_reset),
    .i_div_log2 (cfg_r[15:13]),
    .i_in_tick  (i_root_tick),
    .o_tick     (ahb_t)
  );
  mcc_prescaler #(.W(7)) u_apb1 (
    .i_sys_clk  (i_sys_clk),
    .i_reset    (i_reset),
    .i_div_log2 (cfg_r[18:16]),
    .i_in_tick  (ahb_t),
    .o_tick     (apb1_t)
  );
  mcc_prescaler #(.W(7)) u_apb2 (
    .i_sys_clk  (i_sys_clk),
    .i_reset    (i_reset),
    .i_div_log2 (cfg_r[21:19]),
    .i_in_tick  (ahb_t),
    .o_tick     (apb2_t)
  );

  // ----------------------------------------
  // outputs and clock outputs
  // ----------------------------------------
  // slow mco sources survive stop; of the two clock outputs only slow_clock_output survives standby
  wire mco_slow = ksel_r[22:20] >= MCO_FIRST_SLOW;
  wire mco_nxt  = ksel_r[23] && !i_standby && (!i_stop_mode || mco_slow);
  wire [31:0] stat_w = {19'h0, i_osc_rdy, flag_r, st_r != SW_IDLE,
                        o_root_sel};
  wire [31:0] rd_w = i_addr == OFS_CTRL ? ctrl_r
                   : i_addr == OFS_CFG  ? cfg_r
                   : i_addr == OFS_GATE ? gate_r
                   : i_addr == OFS_KSEL ? ksel_r
                   : i_addr == OFS_STAT ? stat_w
                   : i_addr == OFS_TRIM ? {24'h0, trim_r} : 32'h0;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata         <= 32'h0;
      o_ahb_tick      <= 1'b0;
      o_apb1_tick     <= 1'b0;
      o_apb2_tick     <= 1'b0;
      o_mco_en        <= 1'b0;
      o_slow_clock_output_en       <= 1'b0;
    end else begin
      o_rdata     <= i_rd ? rd_w : 32'h0;
      o_ahb_tick  <= ahb_t;
      o_apb1_tick <= apb1_t;
      o_apb2_tick <= apb2_t;
      o_mco_en    <= mco_nxt;
      o_slow_clock_output_en   <= ksel_r[25];
    end
  end

  // straight register fields
  assign o_msi_range     = ctrl_r[3:0];
  assign o_msi_trim      = trim_r;
  assign o_lse_bypass    = ctrl_r[7];
  assign o_lse_drive     = ctrl_r[9:8];
  assign o_pll_src       = cfg_r[3:2];
  assign o_pll_n         = cfg_r[7:4];
  assign o_pll_m         = cfg_r[9:8];
  assign o_pll_out_en    = cfg_r[12:10];
  assign o_core_clk_en   = gate_r[0];
  assign o_mem_clk_en    = gate_r[2:1];
  assign o_periph_clk_en = gate_r[31:16];
  assign o_kernel_sel    = ksel_r[13:0];
  assign o_rtc_sel       = ksel_r[17:16];
  assign o_rf_slow_sel   = ksel_r[18];
  assign o_mco_sel       = ksel_r[22:20];
  assign o_slow_clock_output_sel      = ksel_r[24];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reset_root_msi: assert property ($past(i_reset) |->
    o_root_sel == ROOT_MSI && o_msi_range == MSI_RANGE_RST)
    else $error("root not multispeed rc after reset");
  a_range_legal: assert property (o_msi_range < MSI_RANGES)
    else $error("illegal multispeed range");
  a_pll_limit: assert property (cur_pll <= FMAX_KHZ)
    else $error("pll above limit");
  a_ahb_limit: assert property (ahb_khz <= FMAX_KHZ)
    else $error("ahb above limit");
  a_swap_gated: assert property ($changed(o_root_sel) |->
    !o_root_gate && !$past(o_root_gate) ##1 o_root_gate)
    else $error("root moved while gate open");
  a_swap_ready: assert property (st_r == SW_OFF |-> $past(tgt_rdy))
    else $error("switch before source ready");
  a_css_fallback: assert property (css_hit && tgt_rdy |->
    ##[1:6] o_root_sel == ROOT_HSI)
    else $error("no fallback after crystal loss");
  a_lse_flag: assert property (lse_fail && lcss_en |=> flag_r[1])
    else $error("slow crystal failure not flagged");
  a_mco_stop: assert property (i_stop_mode && !mco_slow
    |=> !o_mco_en)
    else $error("fast clock out running in stop");
  c_switch: cover property (st_r == SW_SWAP ##2 st_r == SW_IDLE);
  c_css: cover property (css_hit);
  c_pll_refused: cover property (pll_bad);
  c_trim_up: cover property (trim_go ##1 trim_r != $past(trim_r));
endmodule

// [mcc_fail_mon.sv]
`timescale 1ns/1ps
// watchdog on oscillator activity: no tick for LIMIT cycles is a failure
module mcc_fail_mon #(
  parameter int LIMIT = 40
) (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_enable,
  input  wire logic i_tick,
  output logic      o_fail
);
  localparam int CW = $clog2(LIMIT + 1);
  logic [CW-1:0] cnt_r;
  logic          hit;
  assign hit = cnt_r == CW'(LIMIT);
  // one pulse per failure; re-armed by a fresh tick or by dropping i_enable
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r  <= '0;
      o_fail <= 1'b0;
    end else begin
      o_fail <= 1'b0;
      if (!i_enable || i_tick)
        cnt_r <= '0;
      else if (cnt_r < CW'(LIMIT)) begin
        cnt_r  <= cnt_r + 1'b1;
        o_fail <= (cnt_r == CW'(LIMIT - 1));
      end
    end
  end
  a_fail_after_gap: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_fail |-> $past(i_enable) && !$past(i_tick) && hit)
    else $error("failure pulse without silent gap");
endmodule

// [mcc_osc_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// oscillator bank stand-in on the far side
// ----------------------------------------
module mcc_osc_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [6:0] i_rdy_mask,
  input  wire logic       i_hse_stop,
  input  wire logic       i_lse_stop,
  output logic [6:0]      o_osc_rdy,
  output logic            o_hse_tick,
  output logic            o_lse_tick,
  output logic            o_msi_tick,
  output logic            o_root_tick
);
  logic [3:0] div_r;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  // ready only as the bench allows, so late sources can be staged
  assign o_osc_rdy   = i_rdy_mask;
  // a stopped crystal stands still: that is the failure being modelled
  assign o_hse_tick  = !i_hse_stop && div_r[0];
  assign o_lse_tick  = !i_lse_stop && (div_r == 4'hf);
  assign o_msi_tick  = 1'b1;
  assign o_root_tick = 1'b1;
endmodule

// [mcc_pkg.sv]
package mcc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG  = 8'h04;
  localparam logic [7:0] OFS_GATE = 8'h08;
  localparam logic [7:0] OFS_KSEL = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_CLR  = 8'h14;
  localparam logic [7:0] OFS_TRIM = 8'h18;
  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [3:0] MSI_RANGE_RST = 4'h6;
  localparam logic [3:0] MSI_RANGES    = 4'hc;
  localparam logic [7:0] MSI_TRIM_RST  = 8'h80;
  localparam logic [31:0] GATE_RST     = 32'hffff_0007;
  localparam logic [1:0] ROOT_MSI = 2'h0;
  localparam logic [1:0] ROOT_HSI = 2'h1;
  localparam logic [1:0] ROOT_HSE = 2'h2;
  localparam logic [1:0] ROOT_PLL = 2'h3;
  localparam logic [1:0] PSRC_OFF = 2'h0;
  localparam logic [2:0] MCO_FIRST_SLOW = 3'h5;
  // ----------------------------------------
  // frequencies in kHz and timing
  // ----------------------------------------
  localparam logic [19:0] HSE_KHZ  = 20'd32000;
  localparam logic [19:0] HSI_KHZ  = 20'd16000;
  localparam logic [19:0] FMAX_KHZ = 20'd64000;
  localparam int SYS_CLK_KHZ = 40000;
  localparam int HSE_TMO_NS  = 1000;
  localparam int LSE_TMO_NS  = 100000;
  localparam int HSE_TMO_CYC = HSE_TMO_NS * SYS_CLK_KHZ / 1000000;
  localparam int LSE_TMO_CYC = LSE_TMO_NS * SYS_CLK_KHZ / 1000000;
  // ----------------------------------------
  // switch sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SW_IDLE = 3'b000,
    SW_WAIT = 3'b001,
    SW_OFF  = 3'b010,
    SW_SWAP = 3'b011,
    SW_ON   = 3'b100
  } mcc_sw_t;
endpackage

// [mcc_prescaler.sv]
`timescale 1ns/1ps
// power-of-two divider giving one enable pulse per divided period
module mcc_prescaler #(
  parameter int W = 7
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset,
  input  wire logic [2:0]   i_div_log2,
  input  wire logic         i_in_tick,
  output logic              o_tick
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] mask;
  logic         wrap;
  assign mask = W'((1 << i_div_log2) - 1);
  assign wrap = (cnt_r & mask) == mask;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      if (i_in_tick)
        cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      o_tick <= i_in_tick & wrap;
    end
  end
endmodule

// [mcu_clock_controller_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module mcu_clock_controller_bench;
  import mcc_pkg::*;
  logic        i_sys_clk, i_reset, i_wr, i_rd, i_stop_mode, i_standby;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, g, k;
  logic [6:0]  rdy_mask, osc_rdy;
  logic        hse_stop, lse_stop, hse_t, lse_t, msi_t, root_t, rd_d;
  logic [1:0]  o_root_sel, o_pll_src, o_mem_clk_en, o_lse_drive, o_rtc_sel;
  logic [1:0]  sel_d, o_pll_m;
  logic        o_apb1_tick, o_apb2_tick, o_slow_clock_output_sel;
  logic        o_root_gate, o_ahb_tick, o_core_clk_en, o_lse_bypass;
  logic        o_rf_slow_sel, o_mco_en, o_slow_clock_output_en, o_css_irq;
  logic [3:0]  o_msi_range, o_pll_n;
  logic [7:0]  o_msi_trim, t;
  logic [2:0]  o_pll_out_en, o_mco_sel;
  logic [15:0] o_periph_clk_en;
  logic [13:0] o_kernel_sel;
  logic [63:0] exp_q[$];
  logic [63:0] ex;
  int          error_cnt, samples_checked, cyc, n, cnt, c1, c2;

  mcc_osc_model OSC (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_rdy_mask(rdy_mask), .i_hse_stop(hse_stop), .i_lse_stop(lse_stop),
    .o_osc_rdy(osc_rdy), .o_hse_tick(hse_t), .o_lse_tick(lse_t),
    .o_msi_tick(msi_t), .o_root_tick(root_t));
  mcc_clock_ctrl #(.LSE_TMO(50)) DUT (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_rdy(osc_rdy),
    .i_hse_tick(hse_t), .i_lse_tick(lse_t), .i_msi_tick(msi_t),
    .i_root_tick(root_t), .i_stop_mode(i_stop_mode),
    .i_standby(i_standby), .o_root_sel(o_root_sel),
    .o_root_gate(o_root_gate), .o_msi_range(o_msi_range),
    .o_msi_trim(o_msi_trim), .o_pll_src(o_pll_src), .o_pll_n(o_pll_n),
    .o_pll_m(o_pll_m), .o_pll_out_en(o_pll_out_en),
    .o_ahb_tick(o_ahb_tick), .o_apb1_tick(o_apb1_tick),
    .o_apb2_tick(o_apb2_tick), .o_core_clk_en(o_core_clk_en),
    .o_mem_clk_en(o_mem_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_lse_drive(o_lse_drive), .o_lse_bypass(o_lse_bypass),
    .o_kernel_sel(o_kernel_sel), .o_rtc_sel(o_rtc_sel),
    .o_rf_slow_sel(o_rf_slow_sel), .o_mco_sel(o_mco_sel),
    .o_mco_en(o_mco_en), .o_slow_clock_output_sel(o_slow_clock_output_sel), .o_slow_clock_output_en(o_slow_clock_output_en),
    .o_css_irq(o_css_irq));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back({m, e});
    @(posedge i_sys_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
  endtask
  task automatic wait_sel(input logic [1:0] s);
    for (n = 0; n < 100 && o_root_sel !== s; n++) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    `CHK("wait_sel", s, o_root_sel)
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    rd_d <= i_rd;
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end
  always @(negedge i_sys_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      `CHK("rdata", ex[31:0], o_rdata & ex[63:32])
    end
    // select may only move while the root gate is closed
    if (!i_reset && o_root_sel !== sel_d)
      `CHK("gate_at_swap", 1'b0, o_root_gate)
    sel_d = o_root_sel;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_reset = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00;
    i_wdata = 32'h0; i_stop_mode = 1'b0; i_standby = 1'b0;
    rdy_mask = 7'h7f; hse_stop = 1'b0; lse_stop = 1'b0;
    rd_d = 1'b0; sel_d = ROOT_MSI;
    void'($urandom(32'he720d68f));
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(negedge i_sys_clk);
    `CHK("root_sel", ROOT_MSI, o_root_sel)
    `CHK("root_gate", 1'b1, o_root_gate)
    `CHK("msi_range", MSI_RANGE_RST, o_msi_range)
    `CHK("core_en", GATE_RST[0], o_core_clk_en)
    rd(OFS_STAT, 32'h0, 32'h7);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    // late fast rc: switch must hold until ready
    rdy_mask <= 7'h7d;
    wr(OFS_CFG, 32'h1);
    repeat (10) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    `CHK("sel_held", ROOT_MSI, o_root_sel)
    rdy_mask <= 7'h7f;
    wait_sel(ROOT_HSI);
    `CHK("sel_hsi", ROOT_HSI, o_root_sel)
    $display("test switch done");
    // range 12 is out of the twelve; drive and bypass fields
    for (int d = 0; d < 4; d++) begin
      t = 8'($urandom);
      wr(OFS_CTRL, {8'h0, t, 6'h0, 2'(d), 8'h8b});
      wr(OFS_CTRL, {8'h0, t, 6'h0, 2'(d), 8'h8c});
      @(negedge i_sys_clk);
      `CHK("range", 4'hb, o_msi_range)
      `CHK("trim", t, o_msi_trim)
      `CHK("drive", 2'(d), o_lse_drive)
      `CHK("bypass", 1'b1, o_lse_bypass)
    end
    // auto trim: msi counts far short of its target, so trim must climb
    wr(OFS_CTRL, 32'h0080_0016);
    repeat (40) @(negedge i_sys_clk);
    `CHK("trim_up", 1'b1, o_msi_trim > 8'h80)
    wr(OFS_CTRL, 32'h0080_0006);
    g = $urandom;
    wr(OFS_GATE, g);
    @(negedge i_sys_clk);
    `CHK("mem_en", g[2:1], o_mem_clk_en)
    `CHK("periph_en", g[31:16], o_periph_clk_en)
    rd(OFS_GATE, g & 32'hffff_0007, 32'hffff_0007);
    k = $urandom & 32'h0007_3fff;
    wr(OFS_KSEL, k);
    @(negedge i_sys_clk);
    `CHK("kernel", k[13:0], o_kernel_sel)
    `CHK("rtc", k[17:16], o_rtc_sel)
    `CHK("rf_slow", k[18], o_rf_slow_sel)
    $display("test fields done");
    // pll: 32 MHz x4 is over the ceiling, x4 over 2 sits on it
    wr(OFS_CFG, 32'h0000_004d);
    rd(OFS_STAT, 32'h20, 32'h20);
    `CHK("pll_n_kept", 4'h0, o_pll_n)
    wr(OFS_CFG, 32'h0000_1d4f);
    wait_sel(ROOT_PLL);
    `CHK("pll_n", 4'h4, o_pll_n)
    `CHK("pll_m", 2'h1, o_pll_m)
    `CHK("pll_src", 2'h3, o_pll_src)
    `CHK("pll_outs", 3'h7, o_pll_out_en)
    `CHK("sel_pll", ROOT_PLL, o_root_sel)
    // ahb by 4, apb1 by a further 2, apb2 undivided
    wr(OFS_CFG, 32'h0001_5d4f);
    cnt = 0;
    c1 = 0;
    c2 = 0;
    // let the ticks of the old ratio drain first
    repeat (3) @(negedge i_sys_clk);
    repeat (64) @(negedge i_sys_clk) begin
      cnt += int'(o_ahb_tick);
      c1 += int'(o_apb1_tick);
      c2 += int'(o_apb2_tick);
    end
    `CHK("ahb_div4", 16, cnt)
    `CHK("apb1_div8", 8, c1)
    `CHK("apb2_div4", 16, c2)
    wr(OFS_CFG, 32'h0000_0000);
    wait_sel(ROOT_MSI);
    $display("test pll done");
    // fast crystal failure with monitor and irq enabled
    wr(OFS_CFG, 32'h2);
    wait_sel(ROOT_HSE);
    wr(OFS_CTRL, 32'h0080_0426);
    hse_stop <= 1'b1;
    wait_sel(ROOT_HSI);
    `CHK("css_fallback", ROOT_HSI, o_root_sel)
    `CHK("css_irq", 1'b1, o_css_irq)
    rd(OFS_STAT, 32'h8, 32'h8);
    hse_stop <= 1'b0;
    wr(OFS_CLR, 32'h8);
    repeat (2) @(negedge i_sys_clk);
    `CHK("css_clr", 1'b0, o_css_irq)
    // slow crystal failure
    wr(OFS_CTRL, 32'h0080_0846);
    lse_stop <= 1'b1;
    for (n = 0; n < 150 && o_css_irq !== 1'b1; n++) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    `CHK("lse_irq", 1'b1, o_css_irq)
    rd(OFS_STAT, 32'h10, 32'h10);
    lse_stop <= 1'b0;
    wr(OFS_CLR, 32'h10);
    repeat (2) @(negedge i_sys_clk);
    `CHK("lse_clr", 1'b0, o_css_irq)
    $display("test failure done");
    // clock outputs across low power states
    wr(OFS_KSEL, 32'h02d0_0000);
    @(posedge i_sys_clk);
    i_stop_mode <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    `CHK("mco_slow_stop", 1'b1, o_mco_en)
    `CHK("mco_sel", 3'h5, o_mco_sel)
    wr(OFS_KSEL, 32'h0390_0000);
    repeat (3) @(negedge i_sys_clk);
    `CHK("mco_fast_stop", 1'b0, o_mco_en)
    `CHK("slow_clock_output_sel", 1'b1, o_slow_clock_output_sel)
    @(posedge i_sys_clk);
    i_standby <= 1'b1;
    repeat (3) @(negedge i_sys_clk);
    `CHK("slow_clock_output_standby", 1'b1, o_slow_clock_output_en)
    $display("test outputs done");
    repeat (4) @(posedge i_sys_clk);
    finish_test();
  end
endmodule
